// [hw/can_timing_pkg.sv]
/*
   Package for the CAN bit-timing configuration block: register indices,
   field positions, reset values and timing figures.
   Assumes one 50 MHz system clock standing in for the device oscillator.
*/
// Functional notes
// - Time quantum lasts two times prescaler plus one oscillator periods (2..128).
// - Jump width field bits 7-6 limits resynchronization to value plus one quanta.
// - First timing register is writable only in configuration mode.
// - Phase 2 select set: phase 2 free; clear: max of phase 1 and processing time.
// - Phase 1 lasts field bits 5-3 plus one quanta, 1 to 8.
// - Propagation lasts field bits 2-0 plus one quanta, 1 to 8.
// - Freely programmed phase 2 lasts its three-bit field plus one quanta.
// - Phase 2 field is ignored while the phase 2 select bit is clear.
package can_timing_pkg;
   localparam logic [1:0] ADDR_TIMING_ONE   = 2'h0;
   localparam logic [1:0] ADDR_TIMING_TWO   = 2'h1;
   localparam logic [1:0] ADDR_TIMING_THREE = 2'h2;
   localparam logic [1:0] ADDR_STATUS       = 2'h3;
   localparam logic [7:0] RESET_TIMING_ONE  = 8'h00;
   localparam logic [7:0] RESET_TIMING_TWO  = 8'h00;
   localparam logic [7:0] RESET_TIMING_THREE = 8'h00;
   localparam int SJW_MSB   = 7;
   localparam int SJW_LSB   = 6;
   localparam int BRP_MSB   = 5;
   localparam int BRP_LSB   = 0;
   localparam int PH2SEL_BIT = 7;
   localparam int TRIPLE_BIT = 6;
   localparam int PH1_MSB   = 5;
   localparam int PH1_LSB   = 3;
   localparam int PROP_MSB  = 2;
   localparam int PROP_LSB  = 0;
   localparam int PH2_MSB   = 2;
   localparam int PH2_LSB   = 0;
   // Information processing time in quanta
   localparam logic [3:0] INFO_PROC_TQ = 4'h2;
   // Triple samples are one clock apart
   localparam logic [7:0] TRIPLE_GAP = 8'h01;
   typedef enum logic [2:0] {SEG_SYNC, SEG_PROP, SEG_PH1, SEG_PH2} seg_t;
endpackage

// [hw/quantum_divider.sv]
/*
   Quantum divider: one-cycle enable pulse every 2*(P+1) clocks.
   Assumes the prescaler is stable or that a restart on change is fine.
*/
`timescale 1ns/1ps
`default_nettype none
module quantum_divider (
   input  wire logic       clk_sys,
   input  wire logic       arst_n,
   input  wire logic [5:0] quantum_prescaler,
   output logic            tq_tick
);
   logic [6:0] cnt_q;
   logic [6:0] last;

   // Terminal count 2*(P+1)-1
   assign last = {quantum_prescaler, 1'b1};

   // Counter and tick
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         cnt_q   <= 7'h00;
         tq_tick <= 1'b0;
      end else if (cnt_q >= last) begin
         cnt_q   <= 7'h00;
         tq_tick <= 1'b1;
      end else begin
         cnt_q   <= cnt_q + 7'h01;
         tq_tick <= 1'b0;
      end
   end
endmodule
`default_nettype wire

// [hw/can_bit_timing_config.sv]
/*
   CAN bit-timing configuration and bit-time generator with register port.
   Assumes rx_pin comes asynchronously from the transceiver; config_mode
   comes from the controller's mode logic on the same clock.
*/
// Added by the designer: the plain strobed port and the address map.
`timescale 1ns/1ps
`default_nettype none
module can_bit_timing_config (
   input  wire logic       clk_sys,
   input  wire logic       arst_n,
   input  wire logic [1:0] reg_addr,
   input  wire logic [7:0] reg_wdata,
   input  wire logic       reg_wr,
   input  wire logic       reg_rd,
   output logic      [7:0] reg_rdata,
   input  wire logic       config_mode,
   input  wire logic       rx_pin,
   input  wire logic       resync_req,
   input  wire logic [3:0] phase_error,
   output logic            tq_pulse,
   output logic            sample_point,
   output logic            sampled_bit,
   output logic            bit_start,
   output logic      [2:0] sync_jump_width
);
   import can_timing_pkg::*;

   logic [7:0] timing_one_q;
   logic [7:0] timing_two_q;
   logic [7:0] timing_three_q;
   logic       rx_meta_q;
   logic       rx_sync_q;
   logic       tq_tick;
   seg_t       seg_q;
   logic [3:0] seg_cnt_q;
   logic [3:0] ph1_len;
   logic [3:0] ph2_len;
   logic [3:0] prop_len;
   logic [3:0] sjw_len;
   logic [3:0] ph2_ext_q;
   logic [2:0] smp_q;
   logic       in_window_q;

   function automatic logic [3:0] plus_one(input logic [2:0] f);
      return {1'b0, f} + 4'h1;
   endfunction

   function automatic logic maj3(input logic [2:0] s);
      return (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
   endfunction

   quantum_divider u_div (
      .clk_sys           (clk_sys),
      .arst_n            (arst_n),
      .quantum_prescaler (timing_one_q[BRP_MSB:BRP_LSB]),
      .tq_tick           (tq_tick)
   );

   // Segment lengths in quanta
   assign prop_len = plus_one(timing_two_q[PROP_MSB:PROP_LSB]);
   assign ph1_len  = plus_one(timing_two_q[PH1_MSB:PH1_LSB]);
   assign sjw_len  = plus_one({1'b0, timing_one_q[SJW_MSB:SJW_LSB]});
   always_comb begin
      if (timing_two_q[PH2SEL_BIT])
         ph2_len = plus_one(timing_three_q[PH2_MSB:PH2_LSB]);
      else
         ph2_len = (ph1_len > INFO_PROC_TQ) ? ph1_len : INFO_PROC_TQ;
   end

   // Register writes; first register locked outside configuration mode
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         timing_one_q   <= RESET_TIMING_ONE;
         timing_two_q   <= RESET_TIMING_TWO;
         timing_three_q <= RESET_TIMING_THREE;
      end else if (reg_wr) begin
         case (reg_addr)
            ADDR_TIMING_ONE:   if (config_mode) timing_one_q <= reg_wdata;
            ADDR_TIMING_TWO:   timing_two_q <= reg_wdata;
            ADDR_TIMING_THREE: timing_three_q <= {5'h00, reg_wdata[PH2_MSB:PH2_LSB]};
            default:           ;
         endcase
      end
   end

   // Read data, one cycle after the strobe
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n)
         reg_rdata <= 8'h00;
      else if (reg_rd) begin
         case (reg_addr)
            ADDR_TIMING_ONE:   reg_rdata <= timing_one_q;
            ADDR_TIMING_TWO:   reg_rdata <= timing_two_q;
            ADDR_TIMING_THREE: reg_rdata <= timing_three_q;
            ADDR_STATUS:       reg_rdata <= {3'h0, rx_sync_q, config_mode, 1'b0,
                                             sampled_bit, in_window_q};
            default:           reg_rdata <= 8'h00;
         endcase
      end else
         reg_rdata <= 8'h00;
   end

   // Bus line synchroniser
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         rx_meta_q <= 1'b1;
         rx_sync_q <= 1'b1;
      end else begin
         rx_meta_q <= rx_pin;
         rx_sync_q <= rx_meta_q;
      end
   end

   // Segment sequencer: sync, prop, phase 1, phase 2
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         seg_q     <= SEG_SYNC;
         seg_cnt_q <= 4'h0;
         ph2_ext_q <= 4'h0;
         bit_start <= 1'b0;
      end else begin
         bit_start <= 1'b0;
         if (tq_tick) begin
            case (seg_q)
               SEG_SYNC: begin
                  seg_q     <= SEG_PROP;
                  seg_cnt_q <= 4'h1;
                  ph2_ext_q <= 4'h0;
               end
               SEG_PROP: begin
                  if (seg_cnt_q >= prop_len) begin
                     seg_q     <= SEG_PH1;
                     seg_cnt_q <= 4'h1;
                  end else
                     seg_cnt_q <= seg_cnt_q + 4'h1;
               end
               SEG_PH1: begin
                  if (seg_cnt_q >= ph1_len) begin
                     seg_q     <= SEG_PH2;
                     seg_cnt_q <= 4'h1;
                     // Resync at phase 1 end shortens phase 2 by phase error, capped at jump width
                     if (resync_req)
                        ph2_ext_q <= (phase_error > sjw_len) ? sjw_len : phase_error;
                  end else
                     seg_cnt_q <= seg_cnt_q + 4'h1;
               end
               SEG_PH2: begin
                  // Early edge in phase 2 shortens it, clamped by jump width
                  if ((seg_cnt_q + ph2_ext_q >= ph2_len) || (resync_req &&
                      (ph2_len - seg_cnt_q) <= sjw_len)) begin
                     seg_q     <= SEG_SYNC;
                     seg_cnt_q <= 4'h0;
                     bit_start <= 1'b1;
                  end else
                     seg_cnt_q <= seg_cnt_q + 4'h1;
               end
               default: seg_q <= SEG_SYNC;
            endcase
         end
      end
   end

   // Sampling: the last three synchronised levels feed the vote, so even a
   // two-clock quantum never mixes in a level from the previous bit
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         smp_q        <= 3'h7;
         in_window_q  <= 1'b0;
         sample_point <= 1'b0;
         sampled_bit  <= 1'b1;
      end else begin
         sample_point <= 1'b0;
         in_window_q  <= (seg_q == SEG_PH1) && (seg_cnt_q == ph1_len);
         smp_q        <= {smp_q[1:0], rx_sync_q};
         if (tq_tick && seg_q == SEG_PH1 && seg_cnt_q >= ph1_len) begin
            sample_point <= 1'b1;
            if (timing_two_q[TRIPLE_BIT])
               sampled_bit <= maj3({smp_q[1:0], rx_sync_q});
            else
               sampled_bit <= rx_sync_q;
         end
      end
   end

   // Registered timing outputs
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         tq_pulse        <= 1'b0;
         sync_jump_width <= 3'h1;
      end else begin
         tq_pulse        <= tq_tick;
         sync_jump_width <= sjw_len[2:0];
      end
   end
endmodule
`default_nettype wire

// [tb/can_bit_timing_props.sv]
/* Checker on the bit timing block ports.
   Bound to every can_bit_timing_config instance. */
`timescale 1ns/1ps
`default_nettype none
module can_bit_timing_props
   import can_timing_pkg::*;
(
   input wire logic       clk_sys,
   input wire logic       arst_n,
   input wire logic [1:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic       reg_wr,
   input wire logic       reg_rd,
   input wire logic [7:0] reg_rdata,
   input wire logic       config_mode,
   input wire logic       rx_pin,
   input wire logic       resync_req,
   input wire logic [3:0] phase_error,
   input wire logic       tq_pulse,
   input wire logic       sample_point,
   input wire logic       sampled_bit,
   input wire logic       bit_start,
   input wire logic [2:0] sync_jump_width
);
   logic [7:0] t1_q, t2_q, gap_q;
   logic [2:0] t3_q;
   logic [1:0] ts_q, bs_q, sp_q;
   logic [4:0] qn_q, ph1, ph2, len;
   logic       w1;
   // Expected quanta per bit
   assign w1 = reg_wr && reg_addr == ADDR_TIMING_ONE && config_mode;
   assign ph1 = {2'h0, t2_q[5:3]} + 5'h01;
   assign ph2 = t2_q[7] ? {2'h0, t3_q} + 5'h01 : (ph1 > 5'h02 ? ph1 : 5'h02);
   assign len = 5'h02 + {2'h0, t2_q[2:0]} + ph1 + ph2;
   // Shadow of the timing fields
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         t1_q <= 8'h00;
         t2_q <= 8'h00;
         t3_q <= 3'h0;
      end else if (reg_wr) begin
         if (w1) t1_q <= reg_wdata;
         if (reg_addr == ADDR_TIMING_TWO) t2_q <= reg_wdata;
         if (reg_addr == ADDR_TIMING_THREE) t3_q <= reg_wdata[2:0];
      end
   end
   // Settling and per-bit counters
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         ts_q <= 2'h0;
         bs_q <= 2'h0;
         gap_q <= 8'h00;
         qn_q <= 5'h00;
         sp_q <= 2'h0;
      end else begin
         ts_q <= w1 ? 2'h0 : ts_q + {1'b0, tq_pulse && ts_q != 2'h3};
         bs_q <= reg_wr ? 2'h0 : bs_q + {1'b0, bit_start && bs_q != 2'h3};
         gap_q <= tq_pulse ? 8'h01 : gap_q + 8'h01;
         qn_q <= (bit_start ? 5'h00 : qn_q) + {4'h0, tq_pulse};
         sp_q <= (bit_start ? 2'h0 : sp_q) + {1'b0, sample_point};
      end
   end
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!arst_n);
   property p_tq_single;
      tq_pulse |=> !tq_pulse;
   endproperty
   a_tq_single: assert property (p_tq_single) else $error("quantum pulse too long");
   property p_tq_gap;
      tq_pulse && ts_q == 2'h3 |-> gap_q == {1'b0, t1_q[5:0], 1'b0} + 8'h02;
   endproperty
   a_tq_gap: assert property (p_tq_gap) else $error("quantum length wrong");
   property p_sjw;
      !w1 && !$past(w1) && !$past(w1, 2) |-> sync_jump_width == {1'b0, t1_q[7:6]} + 3'h1;
   endproperty
   a_sjw: assert property (p_sjw) else $error("jump width wrong");
   property p_lock;
      reg_wr && reg_addr == ADDR_TIMING_ONE && !config_mode |=> $stable(sync_jump_width)[*3];
   endproperty
   a_lock: assert property (p_lock) else $error("locked write took effect");
   property p_bit_len;
      bit_start && bs_q == 2'h3 |-> qn_q == len;
   endproperty
   a_bit_len: assert property (p_bit_len) else $error("bit length wrong");
   property p_one_sample;
      bit_start && bs_q == 2'h3 |-> sp_q == 2'h1;
   endproperty
   a_one_sample: assert property (p_one_sample) else $error("sample count wrong");
   property p_late_sample;
      bit_start |=> !sample_point[*3];
   endproperty
   a_late_sample: assert property (p_late_sample) else $error("sample too early");
   property p_bit_hold;
      $changed(sampled_bit) |-> sample_point || $past(sample_point);
   endproperty
   a_bit_hold: assert property (p_bit_hold) else $error("bit moved off sample");
endmodule
bind can_bit_timing_config can_bit_timing_props chk (.*);
`default_nettype wire

// [tb/bus_line_model.sv]
/* Bus line model: one new level per bit time.
   Assumes bit_start marks each bit boundary. */
`timescale 1ns/1ps
`default_nettype none
module bus_line_model (
   input  wire logic clk_sys,
   input  wire logic arst_n,
   input  wire logic bit_start,
   output logic      rx_pin
);
   logic [7:0] pat_q;
   // Rotate pattern after each bit, recessive at reset
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) pat_q <= 8'hcb;
      else if (bit_start) pat_q <= {pat_q[0], pat_q[7:1]};
   end
   assign rx_pin = pat_q[0];
endmodule
`default_nettype wire

// [tb/testbench.sv]
/* Testbench for the bit timing block.
   Assumes a 50 MHz clock and the package constants. */
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import can_timing_pkg::*;
   typedef struct packed {
      logic [7:0]  t1, t2, t3;
      logic [15:0] clks;
      logic [2:0]  sjw;
   } row_t;
   logic       clk_sys, arst_n, reg_wr, reg_rd, config_mode, resync_req;
   logic       tq_pulse, sample_point, sampled_bit, bit_start, rx_pin;
   logic [1:0] reg_addr;
   logic [3:0] phase_error;
   logic [7:0] reg_wdata, reg_rdata, d;
   logic [2:0] sync_jump_width;
   int         miscompares, checks_done, cyc, n;
   row_t       rows[5] = '{'{8'h00, 8'h00, 8'h00, 16'h000a, 3'h1},
      '{8'hc1, 8'hbf, 8'hff, 16'h0064, 3'h4}, '{8'h42, 8'h5a, 8'h07, 16'h0048, 3'h2},
      '{8'h80, 8'hc8, 8'hf8, 16'h000a, 3'h3}, '{8'h3f, 8'h00, 8'h00, 16'h0280, 3'h1}};
   can_bit_timing_config uut (.*);
   bus_line_model line (.clk_sys(clk_sys), .arst_n(arst_n), .bit_start(bit_start),
      .rx_pin(rx_pin));
   // Clock and hang guard
   initial begin
      clk_sys = 1'b0;
      forever #10 clk_sys = ~clk_sys;
   end
   always @(posedge clk_sys) begin
      cyc++;
      if (cyc == 20000) begin
         miscompares++;
         end_of_test();
      end
   end
   task automatic chk(input logic [15:0] seen, exp, input string nm);
      checks_done++;
      if (seen !== exp) begin
         miscompares++;
         $display("CHECK FAILED %s exp %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic wr(input logic [1:0] a, input logic [7:0] v);
      @(posedge clk_sys);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= v;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [1:0] a);
      @(posedge clk_sys);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      @(negedge clk_sys);
      d = reg_rdata;
   endtask
   task automatic bitlen();
      do @(negedge clk_sys); while (bit_start !== 1'b1);
      n = 0;
      do begin
         @(negedge clk_sys);
         n++;
      end while (bit_start !== 1'b1);
   endtask
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   // Main sequence
   initial begin
      {arst_n, reg_wr, reg_rd, resync_req, reg_addr, phase_error, reg_wdata} = '0;
      config_mode = 1'b1;
      repeat (16) @(posedge clk_sys);
      arst_n <= 1'b1;
      rd(ADDR_TIMING_TWO);
      chk(d, 8'h00, "reset two");
      chk(16'(sync_jump_width), 3'h1, "reset jump");
      chk(sampled_bit, 1'b1, "reset bit");
      $display("reset test done");
      foreach (rows[i]) begin
         wr(ADDR_TIMING_ONE, rows[i].t1);
         wr(ADDR_TIMING_TWO, rows[i].t2);
         wr(ADDR_TIMING_THREE, rows[i].t3);
         rd(ADDR_TIMING_THREE);
         chk(d, {5'h00, rows[i].t3[2:0]}, "timing three");
         bitlen();
         bitlen();
         chk(n[15:0], rows[i].clks, "bit clocks");
         chk(16'(sync_jump_width), rows[i].sjw, "jump width");
         chk(sampled_bit, rx_pin, "sampled bit");
         $display("row %0d done", i);
      end
      @(posedge clk_sys);
      config_mode <= 1'b0;
      wr(ADDR_TIMING_ONE, 8'hc0);
      rd(ADDR_STATUS);
      chk(d[3], 1'b0, "status mode");
      rd(ADDR_TIMING_ONE);
      chk(d, 8'h3f, "locked one");
      @(posedge clk_sys);
      config_mode <= 1'b1;
      wr(ADDR_TIMING_ONE, 8'hc0);
      rd(ADDR_TIMING_ONE);
      chk(d, 8'hc0, "open one");
      @(negedge clk_sys);
      chk(reg_rdata, 8'h00, "rdata idle");
      $display("lock test done");
      end_of_test();
   end
endmodule
`default_nettype wire
